// >>> src/eid_top.sv
/*
   External interrupt detect: three request pins, trigger control and
   request flags, vectoring toward the CPU in machine-cycle steps, and a
   status/mask interrupt for events. Assumes a plain register port with
   read data one cycle after the read strobe, and CPU status inputs
   that are synchronous to the clock.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module eid_top
   import eid_pkg::*;
(
   // Clock and reset
   input  wire logic       i_clock,
   input  wire logic       i_sys_rst,
   // External request pins
   input  wire logic [2:0] i_ext_irq_pin,
   // CPU status
   input  wire logic       i_insn_last_cycle,
   input  wire logic       i_insn_hold,
   input  wire logic       i_return_from_irq_insn,
   // Register port
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wr_data,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   output logic      [7:0] o_rd_data,
   // Vectoring
   output logic            o_call_start,
   output logic            o_call_busy,
   output logic      [1:0] o_vector_id,
   output logic      [2:0] o_req_flag,
   // Event interrupt
   output logic            o_irq
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed
   {
      logic [2:0] trig_sel;
      logic [2:0] req_flag;
      logic [2:0] edge_fall;
      logic [2:0] edge_rise;
      logic [2:0] enable;
      logic [2:0] pri;
      logic [5:0] sts;
      logic [5:0] msk;
      logic [2:0] polled;
      logic [1:0] in_svc;
      eid_state_t st;
      logic [1:0] call_cnt;
      logic [1:0] vec_id;
      logic       call_start;
      logic       irq;
      logic [7:0] rd_data;
   } eid_state_reg_t;

   eid_state_reg_t s_q;
   eid_state_reg_t s_d;

   // ----------------------------------------
   // Priority pick
   // ----------------------------------------
   // High level first, then lowest input number
   function automatic logic [2:0] eid_pick(input logic [2:0] req,
                                           input logic [2:0] pri);
      logic [2:0] hi;
      logic [2:0] pool;
      logic [2:0] one;
      hi   = req & pri;
      pool = (hi != 3'h0) ? hi : req;
      one  = 3'h0;
      for (int k = 2; k >= 0; k--)
      begin
         if (pool[k])
         begin
            one = 3'h0;
            one[k] = 1'b1;
         end
      end
      return one;
   endfunction

   function automatic logic [1:0] eid_index(input logic [2:0] one);
      logic [1:0] idx;
      idx = 2'h0;
      for (int k = 0; k < 3; k++)
      begin
         if (one[k])
         begin
            idx = 2'(k);
         end
      end
      return idx;
   endfunction

   // ----------------------------------------
   // Timebase and pin detectors
   // ----------------------------------------
   eid_phase_if ph ();

   eid_timebase u_tb
   (
      .i_clock   (i_clock),
      .i_sys_rst (i_sys_rst),
      .ph        (ph.src)
   );

   logic [2:0] pin_low;
   logic [2:0] edge_hit;

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_pin
         eid_pin_detect u_pd
         (
            .i_clock     (i_clock),
            .i_sys_rst   (i_sys_rst),
            .ph          (ph.dst),
            .i_pin       (i_ext_irq_pin[g]),
            .i_edge_fall (s_q.edge_fall[g]),
            .i_edge_rise (s_q.edge_rise[g]),
            .o_low       (pin_low[g]),
            .o_edge_hit  (edge_hit[g])
         );
      end
   endgenerate

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   logic [2:0] cand;
   logic [1:0] cand_id;
   logic       cand_hi;
   logic       blocked;
   logic [5:0] sts_set;
   logic [2:0] sw_flag;
   logic [2:0] sw_flag_we;

   always_comb
   begin
      s_d        = s_q;
      sts_set    = 6'h00;
      sw_flag    = 3'h0;
      sw_flag_we = 3'h0;
      s_d.call_start = 1'b0;

      // Register writes
      if (i_wr)
      begin
         case (i_addr)
            EID_ADDR_CTRL:
            begin
               s_d.trig_sel[0] = i_wr_data[EID_CTRL_TRIG0_BIT];
               s_d.trig_sel[1] = i_wr_data[EID_CTRL_TRIG1_BIT];
               sw_flag[0]      = i_wr_data[EID_CTRL_FLAG0_BIT];
               sw_flag[1]      = i_wr_data[EID_CTRL_FLAG1_BIT];
               sw_flag_we[1:0] = 2'b11;
            end
            EID_ADDR_TRIG:
            begin
               s_d.trig_sel[2] = i_wr_data[EID_TRIG_TRIG2_BIT];
               sw_flag[2]      = i_wr_data[EID_TRIG_FLAG2_BIT];
               sw_flag_we[2]   = 1'b1;
               for (int k = 0; k < 3; k++)
               begin
                  s_d.edge_rise[k] = i_wr_data[2 * k];
                  s_d.edge_fall[k] = i_wr_data[2 * k + 1];
               end
            end
            EID_ADDR_VCTL:
            begin
               s_d.enable = i_wr_data[2:0];
               s_d.pri    = i_wr_data[EID_VCTL_PRI_LSB +: 3];
            end
            EID_ADDR_STS:
            begin
               s_d.sts = s_q.sts & ~i_wr_data[5:0];
            end
            EID_ADDR_MSK:
            begin
               s_d.msk = i_wr_data[5:0];
            end
            default:
            begin
               s_d.sts = s_q.sts;
            end
         endcase
      end

      // Software may write flags only in edge mode; level follows pin
      for (int k = 0; k < 3; k++)
      begin
         if (sw_flag_we[k] && s_q.trig_sel[k])
         begin
            s_d.req_flag[k] = sw_flag[k];
         end
      end

      // Flag phase of each machine cycle; hardware set beats writes
      if (ph.flag_stb)
      begin
         for (int k = 0; k < 3; k++)
         begin
            if (!s_q.trig_sel[k])
            begin
               s_d.req_flag[k] = pin_low[k];
            end
            else if (edge_hit[k])
            begin
               s_d.req_flag[k] = 1'b1;
            end
         end
      end
      sts_set[2:0] = s_d.req_flag & ~s_q.req_flag;

      // Candidate from the flags polled at the previous cycle end
      cand    = eid_pick(s_q.polled & s_q.enable, s_q.pri);
      cand_id = eid_index(cand);
      cand_hi = |(cand & s_q.pri);
      // Service at same or higher level defers the request
      blocked = s_q.in_svc[1] | (s_q.in_svc[0] & ~cand_hi);
      blocked = blocked | ~i_insn_last_cycle;
      blocked = blocked | i_insn_hold;

      // End of service frees the highest active level
      if (i_return_from_irq_insn)
      begin
         if (s_q.in_svc[1])
         begin
            s_d.in_svc[1] = 1'b0;
         end
         else
         begin
            s_d.in_svc[0] = 1'b0;
         end
      end

      // Vectoring, stepped at the end of each machine cycle
      case (s_q.st)
         EID_ST_POLL:
         begin
            if (ph.mc_end)
            begin
               // Unserviced requests are not remembered past this poll
               s_d.polled = s_q.req_flag;
               if ((cand != 3'h0) && !blocked)
               begin
                  s_d.st         = EID_ST_CALL;
                  s_d.call_start = 1'b1;
                  s_d.call_cnt   = 2'h0;
                  s_d.vec_id     = cand_id;
                  s_d.in_svc[cand_hi ? 1 : 0] = 1'b1;
                  sts_set[EID_STS_CALL_LSB + 32'(cand_id)] = 1'b1;
                  // Level flags stay: the source must drop them itself
                  for (int k = 0; k < 3; k++)
                  begin
                     if (cand[k] && s_q.trig_sel[k])
                     begin
                        s_d.req_flag[k] = 1'b0;
                     end
                  end
               end
            end
         end
         EID_ST_CALL:
         begin
            // No polling while the call itself runs
            if (ph.mc_end)
            begin
               if (s_q.call_cnt == EID_CALL_LAST)
               begin
                  s_d.st     = EID_ST_POLL;
                  s_d.polled = 3'h0;
               end
               else
               begin
                  s_d.call_cnt = s_q.call_cnt + 2'h1;
               end
            end
         end
         default:
         begin
            s_d.st = EID_ST_POLL;
         end
      endcase

      // Event flags: a new set wins over a same-cycle clear
      s_d.sts = s_d.sts | sts_set;
      s_d.irq = |(s_d.sts & s_d.msk);

      // Read data, one cycle after the strobe
      s_d.rd_data = EID_ZERO8;
      if (i_rd)
      begin
         case (i_addr)
            EID_ADDR_CTRL:
            begin
               s_d.rd_data[EID_CTRL_TRIG0_BIT] = s_q.trig_sel[0];
               s_d.rd_data[EID_CTRL_FLAG0_BIT] = s_q.req_flag[0];
               s_d.rd_data[EID_CTRL_TRIG1_BIT] = s_q.trig_sel[1];
               s_d.rd_data[EID_CTRL_FLAG1_BIT] = s_q.req_flag[1];
            end
            EID_ADDR_TRIG:
            begin
               s_d.rd_data[EID_TRIG_TRIG2_BIT] = s_q.trig_sel[2];
               s_d.rd_data[EID_TRIG_FLAG2_BIT] = s_q.req_flag[2];
               for (int k = 0; k < 3; k++)
               begin
                  s_d.rd_data[2 * k]     = s_q.edge_rise[k];
                  s_d.rd_data[2 * k + 1] = s_q.edge_fall[k];
               end
            end
            EID_ADDR_VCTL:
            begin
               s_d.rd_data[2:0] = s_q.enable;
               s_d.rd_data[EID_VCTL_PRI_LSB +: 3] = s_q.pri;
            end
            EID_ADDR_STS:
            begin
               s_d.rd_data[5:0] = s_q.sts;
            end
            EID_ADDR_MSK:
            begin
               s_d.rd_data[5:0] = s_q.msk;
            end
            default:
            begin
               s_d.rd_data = EID_ZERO8;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         s_q           <= '0;
         s_q.st        <= EID_ST_POLL;
         s_q.edge_fall <= {EID_TRIG_RST[5], EID_TRIG_RST[3], EID_TRIG_RST[1]};
         s_q.edge_rise <= {EID_TRIG_RST[4], EID_TRIG_RST[2], EID_TRIG_RST[0]};
         s_q.trig_sel  <= {EID_TRIG_RST[EID_TRIG_TRIG2_BIT],
                           EID_CTRL_RST[EID_CTRL_TRIG1_BIT],
                           EID_CTRL_RST[EID_CTRL_TRIG0_BIT]};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign o_rd_data    = s_q.rd_data;
   assign o_call_start = s_q.call_start;
   // One-hot call bit, so the output is a plain flop
   assign o_call_busy  = s_q.st[1];
   assign o_vector_id  = s_q.vec_id;
   assign o_req_flag   = s_q.req_flag;
   assign o_irq        = s_q.irq;
endmodule

// >>> shared/eid_pkg.sv
/*
   Package for the external interrupt detect block: register offsets,
   field positions, reset values, machine-cycle timing and states.
   Assumes one clock at the oscillator rate; twelve clocks per machine cycle.
*/
package eid_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] EID_ADDR_CTRL  = 8'h88;
   localparam logic [7:0] EID_ADDR_TRIG  = 8'h9A;
   localparam logic [7:0] EID_ADDR_VCTL  = 8'hA0;
   localparam logic [7:0] EID_ADDR_STS   = 8'hA1;
   localparam logic [7:0] EID_ADDR_MSK   = 8'hA2;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int EID_CTRL_TRIG0_BIT = 0;
   localparam int EID_CTRL_FLAG0_BIT = 1;
   localparam int EID_CTRL_TRIG1_BIT = 2;
   localparam int EID_CTRL_FLAG1_BIT = 3;
   localparam int EID_TRIG_TRIG2_BIT = 7;
   localparam int EID_TRIG_FLAG2_BIT = 6;
   localparam int EID_VCTL_PRI_LSB   = 4;
   localparam int EID_STS_CALL_LSB   = 3;
   // ----------------------------------------
   // Reset values
   // ----------------------------------------
   localparam logic [7:0] EID_CTRL_RST = 8'h00;
   localparam logic [7:0] EID_TRIG_RST = 8'h2A;
   localparam logic [7:0] EID_ZERO8    = 8'h00;
   // ----------------------------------------
   // Machine-cycle timing
   // ----------------------------------------
   localparam int EID_CLK_PER_MC      = 12;
   localparam int EID_FLAG_PHASE      = 9;
   localparam int EID_MC_END_PHASE    = EID_CLK_PER_MC - 1;
   localparam int EID_CALL_MC         = 2;
   localparam logic [3:0] EID_FLAG_PH = 4'(EID_FLAG_PHASE);
   localparam logic [3:0] EID_END_PH  = 4'(EID_MC_END_PHASE);
   localparam logic [1:0] EID_CALL_LAST = 2'(EID_CALL_MC - 1);
   // ----------------------------------------
   // Vectoring states
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      EID_ST_POLL = 2'b01,
      EID_ST_CALL = 2'b10
   } eid_state_t;
endpackage

// >>> shared/eid_phase_if.sv
/*
   Interface carrying machine-cycle phase strobes from the timebase
   to the pin detectors and the top. Assumes one clock domain.
*/
`timescale 1ns/10ps
interface eid_phase_if;
   logic       flag_stb;
   logic       mc_end;
   logic [3:0] phase;
   modport src (output flag_stb, output mc_end, output phase);
   modport dst (input flag_stb, input mc_end, input phase);
endinterface

// >>> src/eid_timebase.sv
/*
   Machine-cycle timebase: counts oscillator clocks into phases and
   strobes the flag sample phase and the last phase of each cycle.
   Assumes a synchronous active-high reset.
*/
`timescale 1ns/10ps
module eid_timebase
   import eid_pkg::*;
(
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // Phase strobes
   eid_phase_if.src  ph
);
   typedef struct packed
   {
      logic [3:0] phase;
   } eid_tb_state_t;

   eid_tb_state_t s_q;
   eid_tb_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (s_q.phase == EID_END_PH)
      begin
         s_d.phase = 4'h0;
      end
      else
      begin
         s_d.phase = s_q.phase + 4'h1;
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign ph.phase    = s_q.phase;
   assign ph.flag_stb = (s_q.phase == EID_FLAG_PH);
   assign ph.mc_end   = (s_q.phase == EID_END_PH);
endmodule

// >>> src/eid_pin_detect.sv
/*
   One external request pin: keeps the last machine-cycle sample and
   reports a low level or a selected transition at the flag phase.
   Assumes the pin is synchronous to the clock.
*/
`timescale 1ns/10ps
module eid_pin_detect
   import eid_pkg::*;
(
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_sys_rst,
   // Phase strobes
   eid_phase_if.dst  ph,
   // Pin and edge select
   input  wire logic i_pin,
   input  wire logic i_edge_fall,
   input  wire logic i_edge_rise,
   // Detection
   output logic      o_low,
   output logic      o_edge_hit
);
   typedef struct packed
   {
      logic smp;
   } eid_pd_state_t;

   eid_pd_state_t s_q;
   eid_pd_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      o_low = ~i_pin;
      // Two samples one machine cycle apart must differ
      o_edge_hit = ph.flag_stb & (s_q.smp != i_pin)
                 & ((i_edge_rise & i_pin) | (i_edge_fall & ~i_pin));
      if (ph.flag_stb)
      begin
         s_d.smp = i_pin;
      end
   end

   // Idle-high pin after reset, so no false rising edge
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         s_q <= '1;
      end
      else
      begin
         s_q <= s_d;
      end
   end
endmodule

// >>> tb/eid_top_properties.sv
/*
   Checker for the external interrupt detect top: call pulse and length,
   machine-cycle phase of flag and call updates, idle read data.
   Assumes it is bound to the top and sees only the top's ports.
*/
`timescale 1ns/10ps
module eid_top_chk
   import eid_pkg::*;
(
   // Clock and reset
   input wire logic       i_clock,
   input wire logic       i_sys_rst,
   // Register port
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic [7:0] o_rd_data,
   // Vectoring
   input wire logic       o_call_start,
   input wire logic       o_call_busy,
   input wire logic [1:0] o_vector_id,
   input wire logic [2:0] o_req_flag
);
   // ----------------------------------------
   // Phase and busy counters
   // ----------------------------------------
   logic [3:0] ph_q;
   logic [4:0] busy_q;
   always_ff @(posedge i_clock)
   begin
      if (i_sys_rst)
      begin
         ph_q   <= 4'h0;
         busy_q <= 5'h00;
      end
      else
      begin
         ph_q   <= (ph_q == EID_END_PH) ? 4'h0 : ph_q + 4'h1;
         busy_q <= o_call_busy ? busy_q + 5'h01 : 5'h00;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   sequence call_open_s;
      o_call_start && o_call_busy;
   endsequence
   sequence call_run_s;
      (o_call_busy && !o_call_start) [*8];
   endsequence
   call_open_a: assert property (o_call_start |-> o_call_busy && !$past(o_call_busy))
      else $error("call start outside a fresh call");
   call_run_a: assert property (call_open_s |=> call_run_s)
      else $error("call busy dropped early");
   busy_len_a: assert property ($fell(o_call_busy) |-> busy_q == 5'h18)
      else $error("call busy length wrong");
   busy_cap_a: assert property (o_call_busy |-> busy_q < 5'h18)
      else $error("call busy too long");
   call_phase_a: assert property (o_call_start |-> ph_q == 4'h0)
      else $error("call start off machine cycle start");
   flag_phase_a: assert property ($changed(o_req_flag) && !$past(i_wr) |-> ph_q inside {4'hA, 4'h0})
      else $error("flag changed off sample phase");
   vector_hold_a: assert property (!o_call_start |-> $stable(o_vector_id))
      else $error("vector changed without call");
   rd_idle_a: assert property (!$past(i_rd) |-> o_rd_data == 8'h00)
      else $error("read data without read");
endmodule

bind eid_top eid_top_chk u_chk
(
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_rd(i_rd),
   .o_rd_data(o_rd_data), .o_call_start(o_call_start), .o_call_busy(o_call_busy),
   .o_vector_id(o_vector_id), .o_req_flag(o_req_flag)
);

// >>> tb/eid_src_model.sv
/*
   Model of the off-chip request sources on the three pins.
   Assumes the pins idle high, as with a pull-up.
*/
`timescale 1ns/10ps
module eid_src_model
   import eid_pkg::*;
(
   // Clock
   input  wire logic       i_clock,
   // Call seen by the sources
   input  wire logic       i_call_start,
   input  wire logic [1:0] i_vector_id,
   // Pins
   output logic      [2:0] o_pin
);
   initial o_pin = 3'h7;
   // Each level held one full machine cycle so one sample sees it
   task automatic drive(input int idx, input logic lvl);
      @(posedge i_clock);
      o_pin[idx] <= lvl;
      repeat (EID_CLK_PER_MC) @(posedge i_clock);
      #1;
   endtask
   // Low held until the call, then released at once
   task automatic level_req(input int idx, output logic ok);
      ok = 1'b0;
      @(posedge i_clock);
      o_pin[idx] <= 1'b0;
      for (int n = 0; n < 200 && !ok; n++)
      begin
         @(posedge i_clock);
         #1;
         ok = (i_call_start === 1'b1) && (i_vector_id == idx);
      end
      @(posedge i_clock);
      o_pin[idx] <= 1'b1;
   endtask
endmodule

// >>> tb/tb_top.sv
/*
   Bench for the external interrupt detect top: register port, edge and
   level detection, vectoring, blocking and event interrupt.
   Assumes the source model drives the pins and the checker is bound.
*/
`timescale 1ns/10ps
module tb_top
   import eid_pkg::*;
;
   logic       i_clock   = 1'b0;
   logic       i_sys_rst = 1'b1;
   logic       last_cyc  = 1'b1;
   logic       hold      = 1'b0;
   logic       return_from_irq_insn      = 1'b0;
   logic [7:0] addr      = 8'h00;
   logic [7:0] wdata     = 8'h00;
   logic       wr        = 1'b0;
   logic       rd        = 1'b0;
   logic [2:0] pin;
   logic [7:0] rdata;
   logic       call_start;
   logic       call_busy;
   logic [1:0] vec;
   logic [2:0] flag;
   logic       irq;
   int         fail_count = 0;
   int         n_checks   = 0;
   logic [7:0] ra [6] = '{8'h88, 8'h9A, 8'hA0, 8'hA1, 8'hA2, 8'h55};
   logic [7:0] re [6] = '{8'h00, 8'h2A, 8'h00, 8'h00, 8'h00, 8'h00};
   always #2 i_clock = ~i_clock;
   eid_src_model SRC (.i_clock(i_clock), .i_call_start(call_start), .i_vector_id(vec), .o_pin(pin));
   eid_top DUT
   (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_ext_irq_pin(pin),
      .i_insn_last_cycle(last_cyc), .i_insn_hold(hold), .i_return_from_irq_insn(return_from_irq_insn),
      .i_addr(addr), .i_wr_data(wdata), .i_wr(wr), .i_rd(rd), .o_rd_data(rdata),
      .o_call_start(call_start), .o_call_busy(call_busy), .o_vector_id(vec),
      .o_req_flag(flag), .o_irq(irq)
   );
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge i_clock);
      wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_clock);
      rd   <= 1'b1;
      addr <= a;
      @(posedge i_clock);
      rd <= 1'b0;
      #1;
      check(rdata, exp);
   endtask
   task automatic pulse_return_from_irq_insn;
      @(posedge i_clock);
      return_from_irq_insn <= 1'b1;
      @(posedge i_clock);
      return_from_irq_insn <= 1'b0;
   endtask
   // Bounded: a call that never comes ends the run
   task automatic wait_call(output int n);
      n = 0;
      while (call_start !== 1'b1)
      begin
         @(posedge i_clock);
         #1;
         n++;
         if (n > 200)
         begin
            fail_count++;
            close_out();
         end
      end
   endtask
   task automatic no_call;
      logic seen;
      seen = 1'b0;
      repeat (48)
      begin
         @(posedge i_clock);
         #1;
         seen = seen | call_start;
      end
      check({7'h00, seen}, 8'h00);
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial
   begin
      int w;
      int n;
      logic ok;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      for (int i = 0; i < 6; i++)
         rd_chk(ra[i], re[i]);
      $display("reset_values done");
      for (int i = 0; i < 4; i++)
      begin
         wr_reg(EID_ADDR_CTRL, 8'h04);
         wr_reg(EID_ADDR_TRIG, 8'(i << 2));
         SRC.drive(1, 1'b0);
         check({7'h00, flag[1]}, {7'h00, i[1]});
         wr_reg(EID_ADDR_CTRL, 8'h04);
         SRC.drive(1, 1'b1);
         check({7'h00, flag[1]}, {7'h00, i[0]});
      end
      $display("edge_select done");
      wr_reg(EID_ADDR_CTRL, 8'h00);
      SRC.drive(0, 1'b0);
      check({7'h00, flag[0]}, 8'h01);
      SRC.drive(0, 1'b1);
      check({7'h00, flag[0]}, 8'h00);
      wr_reg(EID_ADDR_CTRL, 8'h02);
      rd_chk(EID_ADDR_CTRL, 8'h00);
      $display("level_follow done");
      wr_reg(EID_ADDR_CTRL, 8'h01);
      wr_reg(EID_ADDR_TRIG, EID_TRIG_RST);
      wr_reg(EID_ADDR_STS, 8'h3F);
      wr_reg(EID_ADDR_MSK, 8'h09);
      wr_reg(EID_ADDR_VCTL, 8'h01);
      SRC.drive(0, 1'b0);
      wait_call(w);
      check({6'h00, vec}, 8'h00);
      check({7'h00, flag[0]}, 8'h00);
      n = 0;
      while (call_busy === 1'b1 && n < 100)
      begin
         @(posedge i_clock);
         #1;
         n++;
      end
      check({7'h00, (12 + w + n > 36) && (12 + w + n < 108)}, 8'h01);
      rd_chk(EID_ADDR_STS, 8'h09);
      check({7'h00, irq}, 8'h01);
      wr_reg(EID_ADDR_STS, 8'h09);
      @(posedge i_clock);
      #1;
      check({7'h00, irq}, 8'h00);
      $display("edge_call done");
      // Pass 0 is held off by the call still in service
      for (int k = 0; k < 3; k++)
      begin
         if (k > 0)
            pulse_return_from_irq_insn();
         @(posedge i_clock);
         last_cyc <= (k != 1);
         hold     <= (k == 2);
         SRC.drive(0, 1'b1);
         SRC.drive(0, 1'b0);
         no_call();
         @(posedge i_clock);
         last_cyc <= 1'b1;
         hold     <= 1'b0;
         return_from_irq_insn     <= (k == 0);
         @(posedge i_clock);
         return_from_irq_insn <= 1'b0;
         wait_call(w);
         check({6'h00, vec}, 8'h00);
      end
      $display("blocking done");
      pulse_return_from_irq_insn();
      wr_reg(EID_ADDR_VCTL, 8'h04);
      SRC.level_req(2, ok);
      check({7'h00, ok}, 8'h01);
      check({6'h00, vec}, 8'h02);
      $display("level_call done");
      // Source 0 made high level: preempts the low call, then is held off by itself
      wr_reg(EID_ADDR_VCTL, 8'h11);
      for (int k = 0; k < 2; k++)
      begin
         SRC.drive(0, 1'b1);
         SRC.drive(0, 1'b0);
         if (k > 0)
         begin
            no_call();
            pulse_return_from_irq_insn();
         end
         wait_call(w);
         check({6'h00, vec}, 8'h00);
      end
      $display("priority done");
      close_out();
   end
endmodule
